// ==== hdl/ecl_config_loader.sv ====
// config loader: eeprom copy, apb registers, general purpose i/o, user ram
//
// Contract
// - sixteen general inputs and outputs, set and read through registers
// - output register stays writable when i/o unavailable but drives nothing
// - input register reads zero when i/o unavailable
// - lines configured in pairs as input, push-pull or open-drain
// - extended config bits 7:0 give pair direction, one means output
// - extended config bits 15:8 give pair buffer, one means open-drain
// - digital i/o mode disables general i/o, extended config gives directions
// - 128-byte user ram at 0F80h-0FFFh, contents undefined after reset
// - word 0 bits 7:0 load interface select at 0140h
// - core configuration loads bits 6:4,1,0 from word 0 bits 14:12,9,8
// - core configuration bits 3:2 are not loaded from eeprom
// - word 1 bits 7:0 load interface configuration at 0150h
// - spi mode meanings of interface configuration bits 2:0
// - alternate spi mode meanings of interface configuration bits 5,4,1:0
// - host bus mode meanings of interface configuration bits 7:0
// - word 1 bits 15:8 load sync/latch configuration at 0151h
// - word 2 loads sync pulse length at 0982h in full
// - word 3 loads extended configuration at 0152h
// - word 4 loads station alias at 0012h in full
// - word 5 bit 15 loads management link detection bit 2 at 0510h on the first load only, reloads keep it
// - word 5 loads asic configuration bits 15,14,7,6 at 0142h
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps

module ecl_config_loader
  import ecl_pkg::*;
#(
  parameter int GPIO_W = 16,
  parameter logic [7:0] DIGIO_SELECT = 8'h04
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // eeprom word reader
  output logic ee_rd_o,
  output logic [EE_AW-1:0] ee_addr_o,
  input wire logic ee_valid_i,
  input wire logic [15:0] ee_data_i,
  // chip configuration strap: general i/o pins present
  input wire logic chip_gpio_en_i,
  // general purpose pins
  input wire logic [GPIO_W-1:0] gpio_i,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe_o,
  // configuration towards the core
  output logic [7:0] interface_select_o,
  output logic [7:0] core_config_o,
  output logic [7:0] interface_cfg_o,
  output logic [7:0] sync_latch_cfg_o,
  output logic [15:0] ext_cfg_o,
  output logic [7:0] digio_dir_o,
  output logic [15:0] sync_pulse_len_o,
  output logic [15:0] station_alias_o,
  output logic [15:0] asic_cfg_o,
  output logic mgmt_link_det_o,
  output logic load_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ecl_state_t state_r;
  logic [EE_AW-1:0] word_r;
  logic first_done_r;
  logic done_r;
  logic [7:0] if_ctrl_r;
  logic [7:0] core_cfg_r;
  logic [7:0] if_cfg_r;
  logic [7:0] sync_cfg_r;
  logic [15:0] ext_cfg_r;
  logic [15:0] pulse_r;
  logic [15:0] alias_r;
  logic [15:0] asic_r;
  logic [15:0] mgmt_r;
  logic [GPIO_W-1:0] gpo_r;
  logic [GPIO_W-1:0] gpio_o_r;
  logic [GPIO_W-1:0] gpio_oe_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [7:0] ram [0:RAM_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic is_idx(input logic [IDX_W-1:0] a,
                                  input logic [IDX_W-1:0] b);
    is_idx = (a == b);
  endfunction : is_idx

  logic [IDX_W-1:0] idx;
  logic setup;
  logic wr_acc;
  logic hit_alias, hit_ctrl, hit_core, hit_asic, hit_rsvd, hit_ifcfg;
  logic hit_sync, hit_ext, hit_mgmt, hit_pulse, hit_gpo, hit_gpi;
  logic hit_ldc, hit_lds, hit_ram, hit_any;
  logic [RAM_AW-1:0] ram_a;

  assign idx = paddr[ADDR_W-1:IDX_LSB];
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_alias = is_idx(idx, IDX_STATION_ALIAS);
  assign hit_ctrl = is_idx(idx, IDX_INTERFACE_CONTROL);
  assign hit_core = is_idx(idx, IDX_CORE_CONFIGURATION);
  assign hit_asic = is_idx(idx, IDX_ASIC_CONFIGURATION);
  assign hit_rsvd = is_idx(idx, IDX_RESERVED_CONFIG_WORD);
  assign hit_ifcfg = is_idx(idx, IDX_INTERFACE_CONFIGURATION);
  assign hit_sync = is_idx(idx, IDX_SYNC_LATCH_CONFIGURATION);
  assign hit_ext = is_idx(idx, IDX_EXTENDED_INTERFACE_CONFIG);
  assign hit_mgmt = is_idx(idx, IDX_MGMT_CONTROL_STATUS);
  assign hit_pulse = is_idx(idx, IDX_SYNC_PULSE_LENGTH);
  assign hit_gpo = is_idx(idx, IDX_GENERAL_OUTPUTS);
  assign hit_gpi = is_idx(idx, IDX_GENERAL_INPUTS);
  assign hit_ldc = is_idx(idx, IDX_LOAD_CONTROL);
  assign hit_lds = is_idx(idx, IDX_LOAD_STATUS);
  assign hit_ram = (idx[IDX_W-1:RAM_AW] == RAM_IDX_TOP);
  assign ram_a = idx[RAM_AW-1:0];
  assign hit_any = hit_alias | hit_ctrl | hit_core | hit_asic | hit_rsvd |
                   hit_ifcfg | hit_sync | hit_ext | hit_mgmt | hit_pulse |
                   hit_gpo | hit_gpi | hit_ldc | hit_lds | hit_ram;

  ////////////////////////////////////////////////////////////////////////////
  // eeprom load sequencer
  logic ld_word;
  logic reload_req;
  logic [15:0] w;

  assign w = ee_data_i;
  assign ld_word = (state_r == ST_READ) & ee_valid_i;
  assign reload_req = wr_acc & hit_ldc & pwdata[LD_START_BIT];

  logic ld_ctrl, ld_ifcfg, ld_pulse, ld_ext, ld_alias, ld_asic;
  assign ld_ctrl = ld_word & (word_r == EE_W_CTRL_CORE);
  assign ld_ifcfg = ld_word & (word_r == EE_W_IFCFG_SYNC);
  assign ld_pulse = ld_word & (word_r == EE_W_PULSE);
  assign ld_ext = ld_word & (word_r == EE_W_EXTCFG);
  assign ld_alias = ld_word & (word_r == EE_W_ALIAS);
  assign ld_asic = ld_word & (word_r == EE_W_ASIC_MGMT);

  ecl_state_t state_nxt;
  logic [EE_AW-1:0] word_nxt;

  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    case (state_r)
      ST_START: begin
        state_nxt = ST_READ;
        word_nxt = EE_W_CTRL_CORE;
      end
      ST_READ: begin
        if (ee_valid_i) begin
          if (word_r == EE_W_LAST) begin
            state_nxt = ST_IDLE;
          end else begin
            word_nxt = word_r + 3'h1;
          end
        end
      end
      ST_IDLE: begin
        if (reload_req) begin
          state_nxt = ST_START;
        end
      end
      default: state_nxt = ST_START;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_START;
      word_r <= EE_W_CTRL_CORE;
      done_r <= 1'b0;
      first_done_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      if (state_nxt == ST_START) begin
        done_r <= 1'b0;
      end else if (state_r == ST_READ && state_nxt == ST_IDLE) begin
        done_r <= 1'b1;
        first_done_r <= 1'b1;
      end
    end
  end

  assign ee_rd_o = (state_r == ST_READ);
  assign ee_addr_o = word_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers: a load word wins over a bus write
  logic [15:0] wd16;
  logic [7:0] wd8;
  assign wd16 = pwdata[15:0];
  assign wd8 = pwdata[7:0];
  logic [7:0] core_ld;
  assign core_ld = (w[15:8] & CORE_EE_MASK) | (core_cfg_r & CORE_DC_MASK);
  logic [15:0] mgmt_ld;
  assign mgmt_ld = first_done_r ? mgmt_r :
                   ((mgmt_r & MGMT_WR_MASK) |
                    (16'(w[EE_MGMT_LINK_BIT]) << MGMT_LINK_BIT));

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      if_ctrl_r <= RST8;
      core_cfg_r <= RST8;
      if_cfg_r <= RST8;
      sync_cfg_r <= RST8;
      ext_cfg_r <= RST16;
      pulse_r <= RST16;
      alias_r <= RST16;
      asic_r <= RST16;
      mgmt_r <= RST16;
    end else if (ce_i) begin
      if (ld_ctrl) begin
        if_ctrl_r <= w[7:0];
        core_cfg_r <= core_ld;
      end else begin
        if (wr_acc & hit_ctrl) if_ctrl_r <= wd8;
        if (wr_acc & hit_core) begin
          core_cfg_r <= wd8 & (CORE_EE_MASK | CORE_DC_MASK);
        end
      end
      if (ld_ifcfg) begin
        if_cfg_r <= w[7:0];
        sync_cfg_r <= w[15:8];
      end else begin
        if (wr_acc & hit_ifcfg) if_cfg_r <= wd8;
        if (wr_acc & hit_sync) sync_cfg_r <= wd8;
      end
      if (ld_pulse) begin
        pulse_r <= w;
      end else if (wr_acc & hit_pulse) begin
        pulse_r <= wd16;
      end
      if (ld_ext) begin
        ext_cfg_r <= w;
      end else if (wr_acc & hit_ext) begin
        ext_cfg_r <= wd16;
      end
      if (ld_alias) begin
        alias_r <= w;
      end else if (wr_acc & hit_alias) begin
        alias_r <= wd16;
      end
      if (ld_asic) begin
        asic_r <= w & ASIC_MASK;
        mgmt_r <= mgmt_ld;
      end else begin
        if (wr_acc & hit_asic) asic_r <= wd16 & ASIC_MASK;
        if (wr_acc & hit_mgmt) begin
          mgmt_r <= (wd16 & MGMT_WR_MASK) | (mgmt_r & ~MGMT_WR_MASK);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general purpose i/o
  logic gpio_en;
  logic [GPIO_W-1:0] gpio_o_nxt;
  logic [GPIO_W-1:0] gpio_oe_nxt;
  logic [GPIO_W-1:0] gpi_val;

  // digital i/o mode owns the pins instead
  assign gpio_en = chip_gpio_en_i & (if_ctrl_r != DIGIO_SELECT);
  assign gpi_val = gpio_en ? gpio_i : {GPIO_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < GPIO_W; gi++) begin : g_pin
      logic dir_out;
      logic open_drain;
      assign dir_out = ext_cfg_r[DIR_LSB + gi/2];
      assign open_drain = ext_cfg_r[OD_LSB + gi/2];
      // open-drain drives only the low level
      assign gpio_o_nxt[gi] = open_drain ? 1'b0 : gpo_r[gi];
      assign gpio_oe_nxt[gi] = gpio_en & dir_out &
                               (~open_drain | ~gpo_r[gi]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gpo_r <= {GPIO_W{1'b0}};
      gpio_o_r <= {GPIO_W{1'b0}};
      gpio_oe_r <= {GPIO_W{1'b0}};
    end else if (ce_i) begin
      if (wr_acc & hit_gpo) gpo_r <= pwdata[GPIO_W-1:0];
      gpio_o_r <= gpio_o_nxt;
      gpio_oe_r <= gpio_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user ram, no reset: contents undefined
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_acc && hit_ram) begin
      ram[ram_a] <= wd8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data captured in setup, presented in access
  logic [31:0] rd_word;
  logic [15:0] lds_word;

  assign lds_word = (16'(ee_rd_o) << ST_BUSY_BIT) |
                    (16'(done_r) << ST_DONE_BIT);

  assign rd_word =
    ({32{hit_alias}} & {16'h0000, alias_r}) |
    ({32{hit_ctrl}} & {24'h000000, if_ctrl_r}) |
    ({32{hit_core}} & {24'h000000, core_cfg_r}) |
    ({32{hit_asic}} & {16'h0000, asic_r}) |
    ({32{hit_ifcfg}} & {24'h000000, if_cfg_r}) |
    ({32{hit_sync}} & {24'h000000, sync_cfg_r}) |
    ({32{hit_ext}} & {16'h0000, ext_cfg_r}) |
    ({32{hit_mgmt}} & {16'h0000, mgmt_r}) |
    ({32{hit_pulse}} & {16'h0000, pulse_r}) |
    ({32{hit_gpo}} & 32'(gpo_r)) |
    ({32{hit_gpi}} & 32'(gpi_val)) |
    ({32{hit_lds}} & {16'h0000, lds_word}) |
    ({32{hit_ram}} & {24'h000000, ram[ram_a]});

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prdata_r <= RST32;
      pslverr_r <= 1'b0;
    end else if (ce_i) begin
      if (setup) begin
        prdata_r <= pwrite ? RST32 : rd_word;
        pslverr_r <= ~hit_any;
      end
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the core
  assign gpio_o = gpio_o_r;
  assign gpio_oe_o = gpio_oe_r;
  assign interface_select_o = if_ctrl_r;
  assign core_config_o = core_cfg_r;
  assign interface_cfg_o = if_cfg_r;
  assign sync_latch_cfg_o = sync_cfg_r;
  assign ext_cfg_o = ext_cfg_r;
  assign digio_dir_o = ext_cfg_r[DIR_LSB +: 8];
  assign sync_pulse_len_o = pulse_r;
  assign station_alias_o = alias_r;
  assign asic_cfg_o = asic_r;
  // link detection stays off until a load has completed
  assign mgmt_link_det_o = mgmt_r[MGMT_LINK_BIT] & first_done_r;
  assign load_done_o = done_r;

endmodule : ecl_config_loader

// ==== hdl/ecl_pkg.sv ====
// package: register map, field layout and load sequence constants
package ecl_pkg;

  // apb geometry: one register per aligned word, index = byte address / 4
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int IDX_LSB = 2;

  // register indices (printed offsets)
  localparam logic [IDX_W-1:0] IDX_STATION_ALIAS = 12'h012;
  localparam logic [IDX_W-1:0] IDX_INTERFACE_CONTROL = 12'h140;
  localparam logic [IDX_W-1:0] IDX_CORE_CONFIGURATION = 12'h141;
  localparam logic [IDX_W-1:0] IDX_ASIC_CONFIGURATION = 12'h142;
  localparam logic [IDX_W-1:0] IDX_RESERVED_CONFIG_WORD = 12'h144;
  localparam logic [IDX_W-1:0] IDX_INTERFACE_CONFIGURATION = 12'h150;
  localparam logic [IDX_W-1:0] IDX_SYNC_LATCH_CONFIGURATION = 12'h151;
  localparam logic [IDX_W-1:0] IDX_EXTENDED_INTERFACE_CONFIG = 12'h152;
  localparam logic [IDX_W-1:0] IDX_MGMT_CONTROL_STATUS = 12'h510;
  localparam logic [IDX_W-1:0] IDX_SYNC_PULSE_LENGTH = 12'h982;
  // local registers
  localparam logic [IDX_W-1:0] IDX_GENERAL_OUTPUTS = 12'h200;
  localparam logic [IDX_W-1:0] IDX_GENERAL_INPUTS = 12'h201;
  localparam logic [IDX_W-1:0] IDX_LOAD_CONTROL = 12'h202;
  localparam logic [IDX_W-1:0] IDX_LOAD_STATUS = 12'h203;

  // user ram: 128 bytes, one byte per word at indices 0xF80..0xFFF
  localparam int RAM_AW = 7;
  localparam int RAM_DEPTH = 128;
  localparam logic [IDX_W-RAM_AW-1:0] RAM_IDX_TOP = 5'h1F;

  // eeprom words in load order
  localparam int EE_AW = 3;
  localparam logic [EE_AW-1:0] EE_W_CTRL_CORE = 3'h0;
  localparam logic [EE_AW-1:0] EE_W_IFCFG_SYNC = 3'h1;
  localparam logic [EE_AW-1:0] EE_W_PULSE = 3'h2;
  localparam logic [EE_AW-1:0] EE_W_EXTCFG = 3'h3;
  localparam logic [EE_AW-1:0] EE_W_ALIAS = 3'h4;
  localparam logic [EE_AW-1:0] EE_W_ASIC_MGMT = 3'h5;
  localparam logic [EE_AW-1:0] EE_W_LAST = 3'h6;

  // field layout
  localparam logic [7:0] CORE_EE_MASK = 8'h73;
  localparam logic [7:0] CORE_DC_MASK = 8'h0C;
  localparam logic [15:0] ASIC_MASK = 16'hC0C0;
  localparam int MGMT_LINK_BIT = 2;
  localparam int EE_MGMT_LINK_BIT = 15;
  localparam logic [15:0] MGMT_WR_MASK = 16'hFFFB;
  localparam int DIR_LSB = 0;
  localparam int OD_LSB = 8;
  localparam int LD_START_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;

  // reset values
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [31:0] RST32 = 32'h0000_0000;

  typedef enum logic [1:0] {ST_START, ST_READ, ST_IDLE} ecl_state_t;

endpackage : ecl_pkg

// ==== verification/ecl_config_loader_sva.sv ====
// checker: port-level properties of the config loader
`timescale 1ns/100ps

module ecl_config_loader_sva
  import ecl_pkg::*;
#(
  parameter int GPIO_W = 16,
  parameter logic [7:0] DIGIO_SELECT = 8'h04
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic ee_rd_o,
  input wire logic [EE_AW-1:0] ee_addr_o,
  input wire logic ee_valid_i,
  input wire logic [15:0] ee_data_i,
  input wire logic chip_gpio_en_i,
  input wire logic [GPIO_W-1:0] gpio_oe_o,
  input wire logic [7:0] interface_select_o,
  input wire logic [7:0] core_config_o,
  input wire logic [7:0] interface_cfg_o,
  input wire logic [7:0] sync_latch_cfg_o,
  input wire logic [15:0] ext_cfg_o,
  input wire logic [7:0] digio_dir_o,
  input wire logic [15:0] sync_pulse_len_o,
  input wire logic [15:0] station_alias_o,
  input wire logic [15:0] asic_cfg_o,
  input wire logic load_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] d_q;
  always_ff @(posedge clk_i) d_q <= ee_data_i;
  ////////////////////////////////////////////////////////////////////
  sequence s_take(logic [EE_AW-1:0] n);
    ce_i && ee_rd_o && ee_valid_i && ee_addr_o == n;
  endsequence
  property p_sel; s_take(3'h0) |=> interface_select_o == d_q[7:0]; endproperty
  property p_core;
    s_take(3'h0) |=> (core_config_o & 8'h73) ==
      {1'b0, d_q[14:12], 2'b00, d_q[9:8]};
  endproperty
  property p_dc;
    s_take(3'h0) |=> (core_config_o & 8'h0C) == ($past(core_config_o) & 8'h0C);
  endproperty
  property p_w1;
    s_take(3'h1) |=> {sync_latch_cfg_o, interface_cfg_o} == d_q;
  endproperty
  property p_w2; s_take(3'h2) |=> sync_pulse_len_o == d_q; endproperty
  property p_w3; s_take(3'h3) |=> ext_cfg_o == d_q; endproperty
  property p_w4; s_take(3'h4) |=> station_alias_o == d_q; endproperty
  property p_w5; s_take(3'h5) |=> asic_cfg_o == (d_q & 16'hC0C0); endproperty
  property p_adv;
    ce_i && ee_rd_o && ee_valid_i && ee_addr_o != 3'h6 |=>
      ee_addr_o == $past(ee_addr_o) + 3'h1;
  endproperty
  property p_end; s_take(3'h6) |=> !ee_rd_o ##[0:1] load_done_o; endproperty
  property p_dir;
    (ce_i && interface_select_o == DIGIO_SELECT) [*2] |-> gpio_oe_o == '0;
  endproperty
  property p_off;
    (ce_i && !chip_gpio_en_i) [*2] |-> gpio_oe_o == '0;
  endproperty
  property p_err;
    psel && penable && paddr[ADDR_W-1:IDX_LSB] < IDX_STATION_ALIAS |-> pslverr;
  endproperty
  a_sel: assert property (p_sel) else $error("select not loaded");
  a_core: assert property (p_core) else $error("core cfg bad");
  a_dc: assert property (p_dc) else $error("dc bits changed");
  a_w1: assert property (p_w1) else $error("word 1 bad");
  a_w2: assert property (p_w2) else $error("pulse length bad");
  a_w3: assert property (p_w3) else $error("ext cfg bad");
  a_w4: assert property (p_w4) else $error("alias bad");
  a_w5: assert property (p_w5) else $error("asic cfg bad");
  a_adv: assert property (p_adv) else $error("word order bad");
  a_end: assert property (p_end) else $error("load end bad");
  a_dir: assert property (p_dir) else $error("dio mode drives pins");
  a_off: assert property (p_off) else $error("pin driven while off");
  a_err: assert property (p_err) else $error("unmapped index not flagged");
endmodule : ecl_config_loader_sva

bind ecl_config_loader ecl_config_loader_sva #(.GPIO_W(GPIO_W),
  .DIGIO_SELECT(DIGIO_SELECT)) u_sva (
  .clk_i, .resetn_i, .ce_i, .psel, .penable, .pslverr, .ee_rd_o, .ee_addr_o,
  .ee_valid_i, .ee_data_i, .chip_gpio_en_i, .gpio_oe_o, .interface_select_o,
  .core_config_o, .interface_cfg_o, .sync_latch_cfg_o, .ext_cfg_o,
  .digio_dir_o, .sync_pulse_len_o, .station_alias_o, .asic_cfg_o,
  .load_done_o, .paddr);

// ==== verification/ecl_ee_model.sv ====
// model: serial configuration eeprom word reader, prompt or slow
`timescale 1ns/100ps

module ecl_ee_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [111:0] image_i,
  input wire logic slow_i,
  output logic valid_o,
  output logic [15:0] data_o
);
  logic [1:0] wait_r;
  initial begin
    valid_o = 1'b0;
    data_o = 16'hA5A5;
    wait_r = 2'h0;
  end
  // data toggles outside the strobe so stale words never look valid
  always @(posedge clk_i) begin
    if (rd_i === 1'b1 && !valid_o && wait_r == (slow_i ? 2'h3 : 2'h0)) begin
      valid_o <= 1'b1;
      data_o <= image_i[addr_i*16 +: 16];
      wait_r <= 2'h0;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      wait_r <= (rd_i === 1'b1 && !valid_o) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule : ecl_ee_model

// ==== verification/tb_top.sv ====
// testbench: eeprom load, registers, general i/o and user ram
`timescale 1ns/100ps

module tb_top;
  import ecl_pkg::*;
  localparam logic [7:0] DIGIO = 8'h04;
  logic clk_i, resetn_i, ce_i, psel, penable, pwrite, pready, pslverr;
  logic ee_rd_o, ee_valid_i, chip_gpio_en_i, load_done_o, mgmt_link_det_o;
  logic slow, mg1;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] ee_addr_o;
  logic [7:0] dd;
  logic [15:0] ee_data_i, gin, gpio_o, gpio_oe_o, ext, general_outputs;
  wire logic [15:0] gpio_i;
  logic [6:0][15:0] img;
  int err_count = 0;
  int n_tests = 0;
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & gin);
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ecl_config_loader #(.GPIO_W(16), .DIGIO_SELECT(DIGIO)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_rd_o(ee_rd_o),
    .ee_addr_o(ee_addr_o), .ee_valid_i(ee_valid_i), .ee_data_i(ee_data_i),
    .chip_gpio_en_i(chip_gpio_en_i), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_o(gpio_oe_o), .interface_select_o(), .core_config_o(),
    .interface_cfg_o(), .sync_latch_cfg_o(), .ext_cfg_o(), .digio_dir_o(dd),
    .sync_pulse_len_o(), .station_alias_o(), .asic_cfg_o(),
    .mgmt_link_det_o(mgmt_link_det_o), .load_done_o(load_done_o));
  ecl_ee_model u_ee (.clk_i(clk_i), .rd_i(ee_rd_o), .addr_i(ee_addr_o),
    .image_i(img), .slow_i(slow), .valid_o(ee_valid_i), .data_o(ee_data_i));
  ////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("tests=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask : rdc
  task automatic wait_load();
    int n;
    n = 0;
    while (load_done_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      test_done();
    end
  endtask : wait_load
  function automatic logic [6:0][15:0] new_img();
    logic [6:0][15:0] m;
    for (int i = 0; i < 7; i++) m[i] = 16'($urandom);
    m[0] = m[0] & 16'h73FF; // reserved bits zero
    m[5] = m[5] & 16'hC0C0;
    m[6] = 16'h0000;
    return m;
  endfunction : new_img
  function automatic logic [31:0] gexp(input logic [15:0] x,
                                       input logic [15:0] v, input logic en);
    logic [15:0] oe, o;
    for (int i = 0; i < 16; i++) begin
      oe[i] = en && x[i/2] && (!x[8+i/2] || !v[i]);
      o[i] = !x[8+i/2] && v[i];
    end
    return {oe, o};
  endfunction : gexp
  task automatic check_cfg(input logic [1:0] dc);
    rdc(IDX_INTERFACE_CONTROL, {24'h0, img[0][7:0]});
    rdc(IDX_CORE_CONFIGURATION,
        {25'h0, img[0][14:12], dc, img[0][9:8]});
    rdc(IDX_INTERFACE_CONFIGURATION, {24'h0, img[1][7:0]});
    rdc(IDX_SYNC_LATCH_CONFIGURATION, {24'h0, img[1][15:8]});
    rdc(IDX_SYNC_PULSE_LENGTH, {16'h0, img[2]});
    rdc(IDX_EXTENDED_INTERFACE_CONFIG, {16'h0, img[3]});
    rdc(IDX_STATION_ALIAS, {16'h0, img[4]});
    rdc(IDX_ASIC_CONFIGURATION, {16'h0, img[5] & 16'hC0C0});
    rdc(IDX_MGMT_CONTROL_STATUS, {29'h0, mg1, 2'h0});
    chk({31'h0, mgmt_link_det_o}, {31'h0, mg1});
  endtask : check_cfg
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r, w, x;
    logic e, en;
    logic [7:0] sel;
    void'($urandom(32'hB585E523));
    {resetn_i, ce_i, psel, penable, pwrite, slow} = 6'b010000;
    paddr = 14'h0000;
    pwdata = 32'h0;
    gin = 16'h0;
    chip_gpio_en_i = 1'b1;
    img = new_img();
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_load();
    mg1 = img[5][15];
    check_cfg(2'h0);
    $display("test initial load done");
    apb(1'b1, IDX_CORE_CONFIGURATION, 32'h0000000C, r, e);
    img = new_img();
    slow <= 1'b1;
    apb(1'b1, IDX_LOAD_CONTROL, 32'h00000001, r, e);
    repeat (2) @(posedge clk_i);
    chk({31'h0, load_done_o}, 32'h0);
    wait_load();
    check_cfg(2'h3);
    $display("test reload done");
    for (int k = 0; k < 12; k++) begin
      ext = (k == 0) ? 16'h00FF : (k == 1) ? 16'hFFFF : 16'($urandom);
      general_outputs = 16'($urandom);
      sel = (k % 6 == 5) ? DIGIO : 8'h00;
      en = (k % 4 != 3) && (sel != DIGIO);
      gin <= 16'($urandom);
      chip_gpio_en_i <= (k % 4 != 3);
      apb(1'b1, IDX_INTERFACE_CONTROL, {24'h0, sel}, r, e);
      apb(1'b1, IDX_EXTENDED_INTERFACE_CONFIG, {16'h0, ext}, r, e);
      apb(1'b1, IDX_GENERAL_OUTPUTS, {16'h0, general_outputs}, r, e);
      repeat (2) @(posedge clk_i);
      x = gexp(ext, general_outputs, en);
      chk({gpio_oe_o, gpio_o}, x);
      chk({24'h0, dd}, {24'h0, ext[7:0]});
      rdc(IDX_GENERAL_OUTPUTS, {16'h0, general_outputs});
      w = {16'h0, (x[31:16] & x[15:0]) | (~x[31:16] & gin)};
      rdc(IDX_GENERAL_INPUTS, en ? w : 32'h0);
    end
    $display("test general i/o done");
    for (int k = 0; k < 2; k++) begin
      w = {24'h0, 8'($urandom)};
      apb(1'b1, 12'hF80 + 12'(k * 127), w, r, e);
      rdc(12'hF80 + 12'(k * 127), w);
    end
    apb(1'b0, 12'h001, 32'h0, r, e);
    chk({31'h0, e}, 32'h1); // unmapped index flags an error
    rdc(IDX_RESERVED_CONFIG_WORD, 32'h0);
    // write while frozen is lost
    ce_i <= 1'b0;
    apb(1'b1, IDX_STATION_ALIAS, {16'h0, ~img[4]}, r, e);
    ce_i <= 1'b1;
    rdc(IDX_STATION_ALIAS, {16'h0, img[4]});
    $display("test ram and decode done");
    test_done();
  end
endmodule : tb_top
